/* File: shared/dcsp_pkg.sv */
// shared constants and types for the disk command/status port
package dcsp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // task file decode (A1..A0 of the shared command/status slot)
    localparam logic [1:0] ADDR_CMD_STAT = 2'h3;

    // command word field positions
    localparam int CB_OP_HI = 15;
    localparam int CB_OP_LO = 12;
    localparam int CB_V = 11;
    localparam int CB_L = 10;
    localparam int CB_ZERO9 = 9;
    localparam int CB_IE = 8;
    localparam int CB_Z = 7;
    localparam int CB_C = 6;
    localparam int CB_H = 5;
    localparam int CB_M = 4;
    localparam int CB_U = 3;
    localparam int CB_S = 2;
    localparam int CB_E = 1;
    localparam int CB_LO = 0;

    // reset values
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [7:0] UPPER_PEND_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // sector layout
    localparam logic [10:0] SCATTER_LEN = 11'h010;
    localparam logic [10:0] SYNC_LEN = 11'h00B;
    localparam logic [10:0] ID_LEN = 11'h006;
    localparam logic [10:0] SPLICE_LEN = 11'h002;
    localparam logic [10:0] CRC_LEN = 11'h002;
    localparam logic [10:0] EOR_LEN = 11'h002;
    localparam logic [10:0] EOS_MIN = 11'h007;
    localparam logic [10:0] DATA_MIN = 11'h080;
    localparam logic [7:0] SYNC_CHAR = 8'hFE;
    localparam logic [7:0] FILL_BYTE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [3:0] {
        OP_FAULT_CLEAR = 4'h0,
        OP_RETURN_ZERO = 4'h1,
        OP_SEEK = 4'h2,
        OP_READ_ID = 4'h3,
        OP_READ_SECTOR = 4'h4,
        OP_WRITE_SECTOR = 4'h5,
        OP_FORMAT = 4'h6,
        OP_VERIFY = 4'h7
    } dcsp_op_t;

    typedef enum logic [3:0] {
        FLD_IDLE = 4'h0,
        FLD_SCATTER = 4'h1,
        FLD_SYNC1 = 4'h2,
        FLD_MARK1 = 4'h3,
        FLD_ID = 4'h4,
        FLD_SPLICE = 4'h5,
        FLD_SYNC2 = 4'h6,
        FLD_MARK2 = 4'h7,
        FLD_DATA = 4'h8,
        FLD_DCRC = 4'h9,
        FLD_EOR = 4'hA,
        FLD_EOS = 4'hB
    } dcsp_fld_t;

    // decoded macro-command, flags forced to zero where unused
    typedef struct packed {
        dcsp_op_t op;
        logic modV;
        logic modL;
        logic intEn;
        logic volHead;
        logic cylAddr;
        logic headSel;
        logic marginal;
        logic unitServoM;
        logic prioServoP;
        logic flagE;
        logic flagL;
    } dcsp_cmd_t;

    // live drive and buffer state feeding the status word
    typedef struct packed {
        logic bufChipSel;
        logic unitBusy;
        logic unitSelected;
        logic writeProtect;
        logic unitReady;
        logic onCylinder;
        logic seekError;
        logic fault;
        logic bufDataReq;
        logic dataCrcErr;
        logic dataSyncMissing;
        logic idCrcErr;
        logic idNotFound;
    } dcsp_drv_t;

    // identifier field contents
    typedef struct packed {
        logic [7:0] cylHi;
        logic [7:0] cylLo;
        logic [7:0] head;
        logic [7:0] sector;
    } dcsp_id_t;

endpackage : dcsp_pkg

/* File: rtl/dcsp_port.sv */
// command/status port and sector layout sequencer of the disk controller
`timescale 1ns/1ns

// What this block does
// - one address: write stores command, read status
// - byte mode: select high gives upper status
// - opcode decoded from command bits 15..12
// - command bit 8 is interrupt enable
// - bits 7..5 flags, zero for two commands
// - bit 4 marginal, 3..2 unit/priority flags
// - bit 9 zero; bits 10, 11 modifiers
// - upper status bits report buffer select, progress and drive
// - lower status bits report buffer and errors
// - id field: cylinders, head, sector, crc
// - formatted sector follows fixed field sequence
// - completion interrupt only when enabled
module dcsp_port
    import dcsp_pkg::*;
#(
    parameter int LEN_SEL_W = 2 // data length select: 128 << sel
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic byteMode,
    input wire logic tfCs,
    input wire logic readStrobe,
    input wire logic tfWrite,
    input wire logic [1:0] tfAddr,
    input wire logic upperByteSelect,
    input wire logic [15:0] tfDataIn,
    output logic [15:0] tfDataOut,
    output logic tfDataOe,
    input wire dcsp_drv_t drvStat,
    input wire logic cmdDone,
    output logic cmdValid,
    output dcsp_cmd_t cmdWord,
    output logic completionInterrupt,
    input wire logic fmtStart,
    input wire logic byteTick,
    input wire logic [LEN_SEL_W-1:0] sectorLenSel,
    input wire dcsp_id_t idInfo,
    input wire logic [15:0] idCrc,
    input wire logic [15:0] dataCrc,
    input wire logic [7:0] dataByte,
    output logic [7:0] fmtByte,
    output dcsp_fld_t fmtField,
    output logic fmtActive,
    output logic fmtDataReq
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration check: data field must stay within 128..1024 bytes
    if (LEN_SEL_W < 1 || LEN_SEL_W > 2) begin : g_bad_len
        $error("LEN_SEL_W must be 1 or 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // whole module state
    typedef struct packed {
        logic rdPrev;           // strobe history for edge detect
        logic wrPrev;
        logic [7:0] upperPend;  // upper command byte in byte mode
        logic busy;             // command in progress
        logic intEn;            // enable latched from running command
        logic irq;
        logic cmdValid;
        dcsp_cmd_t cmd;
        logic [15:0] dout;
        logic dataOe;
        dcsp_fld_t fld;         // field being emitted
        logic [10:0] cnt;       // byte index within field
        logic [7:0] fmtByte;
        dcsp_fld_t fmtField;
        logic fmtDataReq;
        logic fmtActive;        // sequencer busy, kept as a flop for the pin
    } dcsp_state_t;

    dcsp_state_t st_r;
    dcsp_state_t st_nxt;

    logic slotSel;          // shared command/status slot addressed
    logic rdReq;            // first cycle of a status read
    logic wrReq;            // first cycle of a command write
    logic [15:0] statusWord;
    logic [15:0] rawCmd;
    logic launch;
    logic [10:0] fldLen;
    logic [10:0] dataLen;
    logic [7:0] curByte;

    ////////////////////////////////////////////////////////////////////////
    // normalise a raw command word
    function automatic dcsp_cmd_t decodeCmd(input logic [15:0] w);
        dcsp_cmd_t c;
        logic noFlags;
        c = '0;
        c.op = dcsp_op_t'(w[CB_OP_HI:CB_OP_LO]);
        noFlags = (c.op == OP_FAULT_CLEAR) || (c.op == OP_RETURN_ZERO);
        c.intEn = w[CB_IE];
        c.volHead = noFlags ? 1'b0 : w[CB_Z];
        c.cylAddr = noFlags ? 1'b0 : w[CB_C];
        c.headSel = noFlags ? 1'b0 : w[CB_H];
        c.marginal = (c.op == OP_FAULT_CLEAR) ? 1'b0 : w[CB_M];
        c.unitServoM = w[CB_U];
        c.prioServoP = w[CB_S];
        c.flagE = w[CB_E];
        c.flagL = w[CB_LO];
        // modifier bits; bit 9 never passes on
        c.modL = (c.op == OP_FAULT_CLEAR) ? 1'b0 : w[CB_L];
        c.modV = ((c.op == OP_RETURN_ZERO) || (c.op == OP_SEEK)
                  || (c.op == OP_READ_SECTOR)) ? w[CB_V] : 1'b0;
        return c;
    endfunction : decodeCmd

    ////////////////////////////////////////////////////////////////////////
    // length of each sector field
    always_comb begin
        dataLen = 11'(DATA_MIN << sectorLenSel);
        case (st_r.fld)
            FLD_SCATTER: fldLen = SCATTER_LEN;
            FLD_SYNC1: fldLen = SYNC_LEN;
            FLD_SYNC2: fldLen = SYNC_LEN;
            FLD_ID: fldLen = ID_LEN;
            FLD_SPLICE: fldLen = SPLICE_LEN;
            FLD_DATA: fldLen = dataLen;
            FLD_DCRC: fldLen = CRC_LEN;
            FLD_EOR: fldLen = EOR_LEN;
            FLD_EOS: fldLen = EOS_MIN;
            default: fldLen = 11'h001; // marks and idle: one byte
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // byte that the current field puts on the track
    always_comb begin
        case (st_r.fld)
            FLD_MARK1: curByte = SYNC_CHAR;
            FLD_MARK2: curByte = SYNC_CHAR;
            FLD_ID: begin
                case (st_r.cnt[2:0])
                    3'h0: curByte = idInfo.cylHi;
                    3'h1: curByte = idInfo.cylLo;
                    3'h2: curByte = idInfo.head;
                    3'h3: curByte = idInfo.sector;
                    3'h4: curByte = idCrc[15:8];
                    default: curByte = idCrc[7:0];
                endcase
            end
            FLD_DATA: curByte = dataByte;
            FLD_DCRC: curByte = st_r.cnt[0] ? dataCrc[7:0] : dataCrc[15:8];
            default: curByte = FILL_BYTE; // gaps, sync and padding
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // status word assembly
    always_comb begin
        statusWord[15] = drvStat.bufChipSel;
        statusWord[14] = st_r.busy;
        statusWord[13] = drvStat.unitBusy;
        statusWord[12] = drvStat.unitSelected;
        statusWord[11] = drvStat.writeProtect;
        statusWord[10] = drvStat.unitReady;
        statusWord[9] = drvStat.onCylinder;
        statusWord[8] = drvStat.seekError;
        statusWord[7] = drvStat.bufChipSel;
        statusWord[6] = drvStat.fault;
        statusWord[5] = drvStat.bufDataReq;
        statusWord[4] = 1'b0;
        statusWord[3] = drvStat.dataCrcErr;
        statusWord[2] = drvStat.dataSyncMissing;
        statusWord[1] = drvStat.idCrcErr;
        statusWord[0] = drvStat.idNotFound;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.cmdValid = 1'b0;
        st_nxt.fmtDataReq = 1'b0;
        // chip select with strobe on the slot
        slotSel = tfCs && (tfAddr == ADDR_CMD_STAT);
        rdReq = slotSel && readStrobe && !st_r.rdPrev;
        wrReq = slotSel && tfWrite && !st_r.wrPrev;
        st_nxt.rdPrev = slotSel && readStrobe;
        st_nxt.wrPrev = slotSel && tfWrite;
        st_nxt.dataOe = slotSel && readStrobe;
        rawCmd = tfDataIn;
        launch = 1'b0;

        if (rdReq) begin
            if (byteMode && upperByteSelect) begin
                st_nxt.dout = {8'h00, statusWord[15:8]};
            end else if (byteMode) begin
                st_nxt.dout = {8'h00, statusWord[7:0]};
            end else begin
                st_nxt.dout = statusWord;
            end
            // reading the low half acknowledges the interrupt
            if (!(byteMode && upperByteSelect)) begin
                st_nxt.irq = 1'b0;
            end
        end

        if (wrReq && !st_r.busy) begin
            if (byteMode && upperByteSelect) begin
                st_nxt.upperPend = tfDataIn[7:0];
            end else if (byteMode) begin
                // low byte completes the word
                rawCmd = {st_r.upperPend, tfDataIn[7:0]};
                launch = 1'b1;
            end else begin
                launch = 1'b1;
            end
        end

        if (launch) begin
            st_nxt.cmd = decodeCmd(rawCmd);
            st_nxt.intEn = rawCmd[CB_IE];
            st_nxt.cmdValid = 1'b1;
            st_nxt.irq = 1'b0;
            st_nxt.busy = 1'b1;
        end else if (cmdDone && st_r.busy) begin
            st_nxt.busy = 1'b0;
            // interrupt gated by enable; set beats clear
            if (st_r.intEn) begin
                st_nxt.irq = 1'b1;
            end
        end

        if (st_r.fld == FLD_IDLE) begin
            if (fmtStart) begin
                st_nxt.fld = FLD_SCATTER;
                st_nxt.cnt = 11'h000;
            end
        end else if (byteTick) begin
            st_nxt.fmtByte = curByte;
            st_nxt.fmtField = st_r.fld;
            st_nxt.fmtDataReq = (st_r.fld == FLD_DATA);
            if (st_r.cnt == fldLen - 11'h001) begin
                st_nxt.cnt = 11'h000;
                case (st_r.fld)
                    FLD_SCATTER: st_nxt.fld = FLD_SYNC1;
                    FLD_SYNC1: st_nxt.fld = FLD_MARK1;
                    FLD_MARK1: st_nxt.fld = FLD_ID;
                    FLD_ID: st_nxt.fld = FLD_SPLICE;
                    FLD_SPLICE: st_nxt.fld = FLD_SYNC2;
                    FLD_SYNC2: st_nxt.fld = FLD_MARK2;
                    FLD_MARK2: st_nxt.fld = FLD_DATA;
                    FLD_DATA: st_nxt.fld = FLD_DCRC;
                    FLD_DCRC: st_nxt.fld = FLD_EOR;
                    FLD_EOR: st_nxt.fld = FLD_EOS;
                    default: st_nxt.fld = FLD_IDLE; // after end of sector
                endcase
            end else begin
                st_nxt.cnt = st_r.cnt + 11'h001;
            end
        end
        // active flag follows the next field so the pin needs no gate
        st_nxt.fmtActive = (st_nxt.fld != FLD_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; reset leaves everything idle
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
            st_r.dout <= STATUS_RST;
            st_r.upperPend <= UPPER_PEND_RST;
            st_r.fld <= FLD_IDLE;
            st_r.fmtField <= FLD_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state flops
    assign tfDataOut = st_r.dout;
    assign tfDataOe = st_r.dataOe;
    assign cmdValid = st_r.cmdValid;
    assign cmdWord = st_r.cmd;
    assign completionInterrupt = st_r.irq;
    assign fmtByte = st_r.fmtByte;
    assign fmtField = st_r.fmtField;
    assign fmtActive = st_r.fmtActive;
    assign fmtDataReq = st_r.fmtDataReq;

endmodule : dcsp_port

/* File: testbench/dcsp_port_assertions.sv */
// concurrent checks on the command/status port outputs
`timescale 1ns/1ns
module dcsp_port_assertions
    import dcsp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic byteMode,
    input wire logic tfCs,
    input wire logic readStrobe,
    input wire logic tfWrite,
    input wire logic [1:0] tfAddr,
    input wire logic [15:0] tfDataIn,
    input wire logic [15:0] tfDataOut,
    input wire logic tfDataOe,
    input wire logic cmdValid,
    input wire dcsp_cmd_t cmdWord,
    input wire logic completionInterrupt,
    input wire logic [7:0] fmtByte,
    input wire dcsp_fld_t fmtField,
    input wire logic fmtDataReq
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    property p_valid_cause; cmdValid |-> $past(tfCs && tfWrite && tfAddr == ADDR_CMD_STAT);
    endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("launch without write");
    property p_oe_cause; tfDataOe |-> $past(tfCs && readStrobe && tfAddr == ADDR_CMD_STAT);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
    property p_byte_hi; tfDataOe && byteMode |-> tfDataOut[15:8] == 8'h00; endproperty
    a_byte_hi: assert property (p_byte_hi) else $error("byte read uses upper lane");
    property p_op; cmdValid && !$past(byteMode) |-> cmdWord.op == $past(tfDataIn[15:12]);
    endproperty
    a_op: assert property (p_op) else $error("opcode not from bits 15..12");
    property p_ie; cmdValid && !$past(byteMode) |-> cmdWord.intEn == $past(tfDataIn[8]);
    endproperty
    a_ie: assert property (p_ie) else $error("interrupt enable not bit 8");
    property p_zch; cmdValid && cmdWord.op inside {OP_FAULT_CLEAR, OP_RETURN_ZERO}
        |-> !(cmdWord.volHead || cmdWord.cylAddr || cmdWord.headSel); endproperty
    a_zch: assert property (p_zch) else $error("flags set for clear or rezero");
    property p_marg; cmdValid && cmdWord.op == OP_FAULT_CLEAR |-> !cmdWord.marginal; endproperty
    a_marg: assert property (p_marg) else $error("marginal set in fault clear");
    property p_modv; cmdValid && !(cmdWord.op inside {OP_RETURN_ZERO, OP_SEEK, OP_READ_SECTOR})
        |-> !cmdWord.modV; endproperty
    a_modv: assert property (p_modv) else $error("bit 11 modifier where not allowed");
    property p_irq; $rose(completionInterrupt) |-> cmdWord.intEn; endproperty
    a_irq: assert property (p_irq) else $error("interrupt without enable");
    property p_fill; fmtField inside {FLD_SCATTER, FLD_SYNC1, FLD_SPLICE, FLD_SYNC2, FLD_EOR,
        FLD_EOS} |-> fmtByte == FILL_BYTE; endproperty
    a_fill: assert property (p_fill) else $error("fill field not zero");
    property p_mark; fmtField inside {FLD_MARK1, FLD_MARK2} |-> fmtByte == SYNC_CHAR;
    endproperty
    a_mark: assert property (p_mark) else $error("sync mark wrong");
    property p_data; fmtDataReq |-> fmtField == FLD_DATA; endproperty
    a_data: assert property (p_data) else $error("data taken outside data field");
    // main scenarios reached
    c_launch: cover property (cmdValid);
    c_irq: cover property ($rose(completionInterrupt));
    c_mark2: cover property (fmtField == FLD_MARK2);
endmodule : dcsp_port_assertions

bind dcsp_port dcsp_port_assertions u_chk (.mclk(mclk), .rst(rst), .byteMode(byteMode),
    .tfCs(tfCs), .readStrobe(readStrobe), .tfWrite(tfWrite), .tfAddr(tfAddr),
    .tfDataIn(tfDataIn), .tfDataOut(tfDataOut), .tfDataOe(tfDataOe), .cmdValid(cmdValid),
    .cmdWord(cmdWord), .completionInterrupt(completionInterrupt), .fmtByte(fmtByte),
    .fmtField(fmtField), .fmtDataReq(fmtDataReq));

/* File: testbench/dcsp_host_model.sv */
// host processor model driving the task file bus
`timescale 1ns/1ns
module dcsp_host_model
    import dcsp_pkg::*;
(
    input wire logic mclk,
    input wire logic [15:0] tfDataOut,
    output logic tfCs,
    output logic readStrobe,
    output logic tfWrite,
    output logic [1:0] tfAddr,
    output logic upperByteSelect,
    output logic [15:0] tfDataIn
);
    // idle bus at time zero
    initial begin
        {tfCs, readStrobe, tfWrite, upperByteSelect} = 4'h0;
        tfAddr = 2'h0;
        tfDataIn = 16'hA5C3;
    end
    ////////////////////////////////////////////////////////////////////////
    // strobe, address and command word are driven together in one cycle
    task automatic hostWrite(input logic ub, input logic [15:0] d);
        @(negedge mclk);
        {tfCs, tfWrite, upperByteSelect, tfAddr, tfDataIn} = {2'h3, ub, ADDR_CMD_STAT, d};
        @(negedge mclk);
        {tfCs, tfWrite} = 2'h0;
        // released data lines do not keep the last value
        tfDataIn = ~d;
        @(negedge mclk);
    endtask : hostWrite
    task automatic hostRead(input logic ub, output logic [15:0] d);
        @(negedge mclk);
        {tfCs, readStrobe, upperByteSelect, tfAddr} = {2'h3, ub, ADDR_CMD_STAT};
        @(negedge mclk);
        @(negedge mclk);
        d = tfDataOut;
        {tfCs, readStrobe, upperByteSelect} = 3'h0;
        @(negedge mclk);
    endtask : hostRead
endmodule : dcsp_host_model

/* File: testbench/tb_disk_command_status_port.sv */
// self-checking bench for the command/status port
`timescale 1ns/1ns
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH %0t %s", $time, m); end end
module tb_disk_command_status_port;
    import dcsp_pkg::*;
    logic mclk, rst, byteMode, cmdDone, fmtStart, byteTick;
    logic tfCs, readStrobe, tfWrite, upperByteSelect, tfDataOe, cmdValid, completionInterrupt;
    logic fmtActive, fmtDataReq;
    logic [1:0] tfAddr, sectorLenSel;
    logic [15:0] tfDataIn, tfDataOut, idCrc, dataCrc, rd;
    logic [7:0] dataByte, fmtByte;
    dcsp_drv_t drvStat;
    dcsp_cmd_t cmdWord;
    dcsp_id_t idInfo;
    dcsp_fld_t fmtField;
    int fails = 0, checked = 0, nValid = 0;
    dcsp_port u_dut (.mclk(mclk), .rst(rst), .byteMode(byteMode), .tfCs(tfCs),
        .readStrobe(readStrobe), .tfWrite(tfWrite), .tfAddr(tfAddr),
        .upperByteSelect(upperByteSelect), .tfDataIn(tfDataIn), .tfDataOut(tfDataOut),
        .tfDataOe(tfDataOe), .drvStat(drvStat), .cmdDone(cmdDone), .cmdValid(cmdValid),
        .cmdWord(cmdWord), .completionInterrupt(completionInterrupt), .fmtStart(fmtStart),
        .byteTick(byteTick), .sectorLenSel(sectorLenSel), .idInfo(idInfo), .idCrc(idCrc),
        .dataCrc(dataCrc), .dataByte(dataByte), .fmtByte(fmtByte), .fmtField(fmtField),
        .fmtActive(fmtActive), .fmtDataReq(fmtDataReq));
    dcsp_host_model u_host (.mclk(mclk), .tfDataOut(tfDataOut), .tfCs(tfCs),
        .readStrobe(readStrobe), .tfWrite(tfWrite), .tfAddr(tfAddr),
        .upperByteSelect(upperByteSelect), .tfDataIn(tfDataIn));
    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // launches seen, for refusal checks
    always @(negedge mclk) if (cmdValid === 1'b1) nValid++;
    ////////////////////////////////////////////////////////////////////////
    // expected status word from the live drive levels
    function automatic logic [15:0] stExp(input logic busy);
        return {drvStat.bufChipSel, busy, drvStat.unitBusy, drvStat.unitSelected,
            drvStat.writeProtect, drvStat.unitReady, drvStat.onCylinder, drvStat.seekError,
            drvStat.bufChipSel, drvStat.fault, drvStat.bufDataReq, 1'b0, drvStat.dataCrcErr,
            drvStat.dataSyncMissing, drvStat.idCrcErr, drvStat.idNotFound};
    endfunction : stExp
    // executor reports completion
    task automatic finish();
        @(negedge mclk) cmdDone = 1'b1;
        @(negedge mclk) cmdDone = 1'b0;
        @(negedge mclk);
    endtask : finish
    task automatic give_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////
    // every opcode with all flags set, then status and completion
    task automatic t_opcodes();
        logic [3:0] op;
        int n;
        drvStat = 13'h1555;
        for (int i = 0; i < 8; i++) begin
            op = 4'(i);
            n = nValid;
            u_host.hostWrite(1'b0, {op, 12'hDFF});
            `CHK(nValid, n + 1, "no launch")
            `CHK(cmdWord.op, op, "opcode")
            `CHK(cmdWord.intEn, 1'b1, "irq enable")
            `CHK({cmdWord.volHead, cmdWord.cylAddr, cmdWord.headSel}, {3{op > 4'h1}}, "zch")
            `CHK({cmdWord.marginal, cmdWord.unitServoM, cmdWord.prioServoP}, {op != 4'h0, 2'h3},
                "mus")
            `CHK({cmdWord.modV, cmdWord.modL}, {op inside {4'h1, 4'h2, 4'h4}, op != 4'h0},
                "modifiers")
            u_host.hostRead(1'b0, rd);
            `CHK(rd, stExp(1'b1), "busy status")
            u_host.hostWrite(1'b0, 16'h1000);
            `CHK(nValid, n + 1, "write while busy")
            finish();
            `CHK(completionInterrupt, 1'b1, "irq missing")
            u_host.hostRead(1'b0, rd);
            `CHK(rd, stExp(1'b0), "idle status")
            `CHK(completionInterrupt, 1'b0, "irq not cleared")
        end
        // interrupt disabled; completion while idle ignored
        u_host.hostWrite(1'b0, 16'h20E0);
        finish();
        finish();
        `CHK(completionInterrupt, 1'b0, "irq while disabled")
        $display("test opcodes done");
    endtask : t_opcodes
    // byte mode command and status halves
    task automatic t_byte();
        byteMode = 1'b1;
        drvStat = 13'h0AAA;
        u_host.hostWrite(1'b1, 16'h4949);
        u_host.hostWrite(1'b0, 16'hE0E0);
        `CHK({cmdWord.op, cmdWord.modV, cmdWord.intEn, cmdWord.volHead}, {OP_READ_SECTOR, 3'h7},
            "byte launch")
        finish();
        u_host.hostRead(1'b1, rd);
        `CHK(rd, stExp(1'b0) >> 8, "upper status")
        `CHK(completionInterrupt, 1'b1, "irq cleared by upper")
        u_host.hostRead(1'b0, rd);
        `CHK(rd, stExp(1'b0) & 16'h00FF, "lower status")
        `CHK(completionInterrupt, 1'b0, "irq kept after lower")
        byteMode = 1'b0;
        $display("test byte mode done");
    endtask : t_byte
    // one sector of the selected data length, byte by byte
    task automatic t_format(input logic [1:0] sel);
        logic [7:0] e;
        logic [47:0] idv;
        int n;
        idv = {idInfo, idCrc};
        n = int'(DATA_MIN) << sel;
        sectorLenSel = sel;
        @(negedge mclk) fmtStart = 1'b1;
        @(negedge mclk) fmtStart = 1'b0;
        for (int i = 0; i < 59 + n; i++) begin
            e = (i >= 48 && i < 48 + n) ? 8'(i) : FILL_BYTE;
            if (i == 27 || i == 47) e = SYNC_CHAR;
            if (i >= 28 && i < 34) e = idv[47 - 8 * (i - 28) -: 8];
            if (i >= 48 + n && i < 50 + n) e = dataCrc[15 - 8 * (i - 48 - n) -: 8];
            byteTick = 1'b1;
            dataByte = 8'(i);
            @(negedge mclk) byteTick = 1'b0;
            // data request stands only in the cycle after the tick
            `CHK(fmtByte, e, "sector byte")
            `CHK(fmtDataReq, (i >= 48 && i < 48 + n), "data request")
            @(negedge mclk);
        end
        `CHK(fmtActive, 1'b0, "still active")
        $display("test format done");
    endtask : t_format
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, byteMode, cmdDone, fmtStart, byteTick} = 5'h10;
        {sectorLenSel, dataByte, drvStat} = '0;
        {idInfo, idCrc, dataCrc} = 64'h0312_5A7C_9B2E_C4D1;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        `CHK({cmdValid, completionInterrupt, fmtActive, fmtField}, {3'h0, FLD_IDLE}, "reset")
        t_opcodes();
        t_byte();
        t_format(2'h0);
        t_format(2'h3);
        give_verdict();
    end
    // hang guard, nearly four times the expected run of some 2700 cycles
    initial begin
        repeat (10000) @(posedge mclk);
        fails++;
        give_verdict();
    end
endmodule : tb_disk_command_status_port
